// ==== rtl/qbx_top.v ====
/*
  Two-wire slave exposing eight quasi-bidirectional port pins and an
  open-drain change interrupt. Assumes the bench resolves open-drain
  and pulled-up wires from the enables; all pins are asynchronous.
*/
// Operation
// R1 - Input pin edge pulls interrupt low within 4 us
// R2 - Interrupt clears when pins return or port is read or written
// R3 - Read clears at ack rising edge, write at ack falling edge
// R4 - Interrupt clear takes effect within 4 us of that edge
// R5 - Changes after a clear report after next rising clock edge
// R6 - Transfers to other slaves leave interrupt detection untouched
// R7 - No registers; data byte goes straight to the pins
// R8 - Pin written high gets strong pull-up until next clock fall; code boosts only pins written high that were low before
// R9 - Master should write a pin high before using it as input
// R10 - Start, then address byte MSB first ending in direction bit
// R11 - General call address is never acknowledged
// R12 - Matching address acked by holding data low in ninth pulse
// R13 - Address straps stay stable from start to stop
// R14 - Address is 0100 followed by the three strap values
// R15 - Read returns pins, write drives pins bit n to pin n
// R16 - First write byte acked, later bytes ignored
// R17 - Pins change only after a full byte is acked
// R18 - Written pins valid within 4 us of ack rising edge
// R19 - Read bits valid within 3.4 us after clock falls
// R20 - Stop ends anywhere; pins keep last acked value
// R21 - Reset idles interface and sets all pins weakly high
// R22 - Zero bit drives low, one bit weak pull-up, read samples pins
`timescale 1ns/1ns
`default_nettype none
`include "qbx_consts.vh"

module qbx_top #(
  parameter PORT_W   = `QBX_PORT_W,
  parameter HOLD_CYC = `QBX_SDA_HOLD_CYC
) (
  // Clock and reset
  input  wire              clk_in,
  input  wire              rst_in,
  // Serial bus
  input  wire              scl_in,
  input  wire              sda_in,
  output reg               sda_out,
  output reg               sda_oe_out,
  // Address straps
  input  wire [2:0]        addr_select_straps_in,
  // Port pins
  input  wire [PORT_W-1:0] port_pins_in,
  output reg  [PORT_W-1:0] port_pins_out,
  output reg  [PORT_W-1:0] port_pins_oe_out,
  // Change interrupt, open drain
  output reg               irq_n_out,
  output reg               irq_oe_out
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_AACK  = 3'h2;
  localparam [2:0] ST_WR    = 3'h3;
  localparam [2:0] ST_WACK  = 3'h4;
  localparam [2:0] ST_RD    = 3'h5;
  localparam [2:0] ST_RACK  = 3'h6;
  localparam [2:0] ST_SKIP  = 3'h7;

  localparam [3:0] BYTE_DONE = 4'h8;
  localparam [7:0] HOLD_LOAD = HOLD_CYC[7:0];

  // Synchronised pins
  wire              scl_s;
  wire              sda_s;
  wire [2:0]        strap_s;
  wire [PORT_W-1:0] pins_s;

  qbx_sync #(
    .WIDTH   (5),
    .RST_VAL (5'h1F)
  ) u_sync_bus (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({scl_in, sda_in, addr_select_straps_in}),
    .q_out  ({scl_s, sda_s, strap_s})
  );

  qbx_sync #(
    .WIDTH   (PORT_W),
    .RST_VAL ({PORT_W{1'b1}})
  ) u_sync_pins (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (port_pins_in),
    .q_out  (pins_s)
  );

  // Edge and condition detect
  reg  scl_d_r;
  reg  sda_d_r;
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;

  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s; // see R10
  assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  always @(posedge clk_in) begin
    if (rst_in) begin
      scl_d_r <= `QBX_LINE_RESET;
      sda_d_r <= `QBX_LINE_RESET;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Slave state
  reg [2:0]        state_r;
  reg [3:0]        bit_cnt_r;
  reg [7:0]        rx_r;
  reg [PORT_W-1:0] tx_r;
  reg              rw_r;
  reg [PORT_W-1:0] latch_r;
  reg [PORT_W-1:0] strong_r;
  reg              sda_req_r;
  reg [7:0]        hold_cnt_r;
  reg              hold_run_r;
  reg              irq_clear_r;
  reg              irq_hold_r;
  wire             irq_req;
  wire             addr_hit;

  // Seven-bit match on the fixed nibble and the straps
  function addr_match;
    input [7:0] byte_v;
    input [2:0] strap_v;
    begin
      addr_match = (byte_v[7:1] == {`QBX_ADDR_HI, strap_v}); // see R14
    end
  endfunction

  // Open drain sends a one by letting go of the line
  function bit_pull;
    input [PORT_W-1:0] shift_v;
    begin
      bit_pull = ~shift_v[PORT_W-1];
    end
  endfunction

  // General call 0x00 can never carry the fixed nibble
  assign addr_hit = addr_match(rx_r, strap_s); // see R11 see R14

  always @(posedge clk_in) begin
    if (rst_in) begin
      state_r     <= ST_IDLE; // see R21
      bit_cnt_r   <= 4'h0;
      rx_r        <= 8'h00;
      tx_r        <= {PORT_W{1'b1}};
      rw_r        <= 1'b0;
      latch_r     <= `QBX_PIN_RESET; // see R21
      strong_r    <= {PORT_W{1'b0}};
      sda_req_r   <= 1'b0;
      irq_clear_r <= 1'b0;
      irq_hold_r  <= 1'b0;
    end else begin
      irq_clear_r <= 1'b0;
      irq_hold_r  <= 1'b0;
      // Strong pull-up is only a rising-edge booster
      if (scl_fall) begin
        strong_r <= {PORT_W{1'b0}}; // see R8
      end
      if (bus_stop) begin
        // Latch keeps last acked byte, read data is dropped
        state_r   <= ST_IDLE; // see R20
        sda_req_r <= 1'b0;
      end else if (bus_start) begin
        state_r   <= ST_ADDR; // see R10
        bit_cnt_r <= 4'h0;
        sda_req_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            sda_req_r <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              rx_r      <= {rx_r[6:0], sda_s}; // see R10
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == BYTE_DONE) begin
              bit_cnt_r <= 4'h0;
              if (addr_hit) begin
                rw_r      <= rx_r[0];
                sda_req_r <= 1'b1; // see R12
                state_r   <= ST_AACK;
              end else begin
                // Foreign traffic never touches the detector
                state_r <= ST_SKIP; // see R6
              end
            end
          end
          ST_AACK: begin
            if (scl_rise && rw_r) begin
              tx_r        <= pins_s; // see R15 see R22
              irq_clear_r <= 1'b1; // see R3
            end else if (scl_fall) begin
              if (rw_r) begin
                sda_req_r <= bit_pull(tx_r); // see R19
                tx_r      <= {tx_r[PORT_W-2:0], 1'b1};
                state_r   <= ST_RD;
              end else begin
                sda_req_r <= 1'b0;
                state_r   <= ST_WR;
              end
            end
          end
          ST_WR: begin
            if (scl_rise) begin
              rx_r      <= {rx_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == BYTE_DONE) begin
              bit_cnt_r <= 4'h0;
              sda_req_r <= 1'b1; // see R16
              state_r   <= ST_WACK;
            end
          end
          ST_WACK: begin
            if (scl_rise) begin
              // Pins move only once the byte is acked
              latch_r    <= rx_r[PORT_W-1:0]; // see R7 see R15 see R17 see R18
              strong_r   <= rx_r[PORT_W-1:0] & ~latch_r; // see R8
              irq_hold_r <= 1'b1; // see R5
            end else if (scl_fall) begin
              sda_req_r   <= 1'b0;
              irq_clear_r <= 1'b1; // see R3
              // Later bytes go unanswered and unapplied
              state_r     <= ST_SKIP; // see R16
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == BYTE_DONE) begin
                bit_cnt_r <= 4'h0;
                sda_req_r <= 1'b0;
                state_r   <= ST_RACK;
              end else begin
                sda_req_r <= bit_pull(tx_r); // see R19
                tx_r      <= {tx_r[PORT_W-2:0], 1'b1};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              rw_r <= ~sda_s;
              if (!sda_s) begin
                // Each further byte is a fresh port sample
                tx_r        <= pins_s; // see R15
                irq_clear_r <= 1'b1; // see R2
              end
            end else if (scl_fall) begin
              if (rw_r) begin
                sda_req_r <= bit_pull(tx_r); // see R19
                tx_r      <= {tx_r[PORT_W-2:0], 1'b1};
                state_r   <= ST_RD;
              end else begin
                state_r <= ST_SKIP;
              end
            end
          end
          ST_SKIP: begin
            sda_req_r <= 1'b0;
          end
          default: begin
            state_r   <= ST_IDLE;
            sda_req_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Data line follows the request after a hold delay past clock fall,
  // so the master sees stable data through its own hold window
  always @(posedge clk_in) begin
    if (rst_in) begin
      hold_cnt_r <= 8'h00;
      hold_run_r <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      if (bus_stop || bus_start) begin
        hold_run_r <= 1'b0;
        hold_cnt_r <= 8'h00;
        sda_oe_out <= 1'b0;
      end else if (scl_fall) begin
        hold_run_r <= 1'b1;
        hold_cnt_r <= HOLD_LOAD;
      end else if (hold_run_r) begin
        if (hold_cnt_r == 8'h00) begin
          hold_run_r <= 1'b0;
          sda_oe_out <= sda_req_r; // see R12 see R19
        end else begin
          hold_cnt_r <= hold_cnt_r - 8'h01;
        end
      end
    end
  end

  // Change interrupt
  qbx_chg_det #(
    .WIDTH (PORT_W)
  ) u_chg_det (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pins_in   (pins_s),
    .inputs_in (latch_r),
    .clear_in  (irq_clear_r),
    .hold_in   (irq_hold_r),
    .arm_in    (scl_rise),
    .irq_out   (irq_req)
  );

  // Registered pin drivers
  always @(posedge clk_in) begin
    if (rst_in) begin
      port_pins_out    <= `QBX_PIN_RESET; // see R21
      port_pins_oe_out <= {PORT_W{1'b0}};
      irq_n_out        <= 1'b0;
      irq_oe_out       <= 1'b0;
    end else begin
      // Zero sinks, one is weak unless boosted
      port_pins_out    <= latch_r; // see R22
      port_pins_oe_out <= ~latch_r | strong_r; // see R8 see R22
      irq_n_out        <= 1'b0;
      irq_oe_out       <= irq_req; // see R1 see R4
    end
  end

endmodule

`default_nettype wire

// ==== rtl/qbx_consts.vh ====
/*
  Constants for the quasi-bidirectional port expander: bus address,
  reset values and timing counts. Assumes a 10 ns system clock.
*/
`ifndef QBX_CONSTS_VH
`define QBX_CONSTS_VH

// Fixed upper address nibble, straps fill the low three bits
`define QBX_ADDR_HI            4'h4
`define QBX_ADDR_HI_W          4
`define QBX_STRAP_W            3
`define QBX_PORT_W             8

// Reset values
`define QBX_PIN_RESET          8'hFF
`define QBX_LINE_RESET         1'h1

// Timing, printed figures in ns
`define QBX_CLK_PERIOD_NS      10
`define QBX_IRQ_VALID_NS       4000
`define QBX_IRQ_CLEAR_NS       4000
`define QBX_PIN_VALID_NS       4000
`define QBX_SDA_VALID_NS       3400
`define QBX_SDA_HOLD_NS        300

// Derived cycle counts, longest times round down
`define QBX_IRQ_VALID_CYC      (`QBX_IRQ_VALID_NS / `QBX_CLK_PERIOD_NS)
`define QBX_IRQ_CLEAR_CYC      (`QBX_IRQ_CLEAR_NS / `QBX_CLK_PERIOD_NS)
`define QBX_PIN_VALID_CYC      (`QBX_PIN_VALID_NS / `QBX_CLK_PERIOD_NS)
`define QBX_SDA_VALID_CYC      (`QBX_SDA_VALID_NS / `QBX_CLK_PERIOD_NS)
`define QBX_SDA_HOLD_CYC       (`QBX_SDA_HOLD_NS / `QBX_CLK_PERIOD_NS)

`endif

// ==== rtl/qbx_sync.v ====
/*
  Two-stage synchroniser for a bundle of pin inputs.
  Assumes each bit is independent; no bus coherence is offered.
*/
`timescale 1ns/1ns
`default_nettype none

module qbx_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // Data
  input  wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage feeds only the second
  always @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule

`default_nettype wire

// ==== rtl/qbx_chg_det.v ====
/*
  Change detector behind the interrupt line.
  Assumes synchronised pins and one-cycle clear, hold and arm pulses.
*/
`timescale 1ns/1ns
`default_nettype none
`include "qbx_consts.vh"

module qbx_chg_det #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // Pin state
  input  wire [WIDTH-1:0] pins_in,
  input  wire [WIDTH-1:0] inputs_in,
  // Control pulses
  input  wire             clear_in,
  input  wire             hold_in,
  input  wire             arm_in,
  // Result
  output reg              irq_out
);

  reg  [WIDTH-1:0] ref_r;
  reg              mask_r;
  wire             diff;

  // Only pins left high act as inputs
  assign diff = |((pins_in ^ ref_r) & inputs_in);

  always @(posedge clk_in) begin
    if (rst_in) begin
      ref_r   <= `QBX_PIN_RESET;
      mask_r  <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      // Snapshot re-arms detection
      if (clear_in) begin
        ref_r <= pins_in; // see R2
      end
      // Clear beats arm, so mask lasts to the next rising edge
      if (clear_in || hold_in) begin
        mask_r <= 1'b1;
      end else if (arm_in) begin
        mask_r <= 1'b0; // see R5
      end
      // Returning to the snapshot drops the request by itself
      irq_out <= diff & ~mask_r & ~clear_in & ~hold_in; // see R1 see R2
    end
  end

endmodule

`default_nettype wire

// ==== dv/qbx_master_model.sv ====
/*
  Two-wire bus master model: start, stop, bit and byte tasks.
  Assumes the bench resolves a pulled-up data line from all enables.
*/
`timescale 1ns/1ns
`default_nettype none

module qbx_master_model (
  // Bus lines
  output logic     scl_out,
  output logic     sda_low_out,
  input  wire logic sda_in
);
  // Clock idles high outside frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic start_cond();
    // Keep every pin edge clear of the system clock edge
    #2;
    #40 sda_low_out = 1'b0;
    #40 scl_out = 1'b1;
    #80 sda_low_out = 1'b1;
    #80 scl_out = 1'b0;
  endtask

  task automatic stop_cond();
    #40 sda_low_out = 1'b1;
    #40 scl_out = 1'b1;
    #80 sda_low_out = 1'b0;
    #400;
  endtask

  // Long low phase, so the slave lets go before the next rise
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low_out = !b;
    #40 scl_out = 1'b1;
    #45 r = sda_in;
    scl_out = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Master acks unless this is the last byte
  task automatic get_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, r);
  endtask
endmodule

`default_nettype wire

// ==== dv/qbx_top_assertions.sv ====
/*
  Concurrent checks on the expander top.
  Assumes one 100 MHz domain and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module qbx_checker #(
  parameter PORT_W = 8
) (
  // Clock and reset
  input wire logic              clk_in,
  input wire logic              rst_in,
  // Serial bus
  input wire logic              scl_in,
  input wire logic              sda_in,
  input wire logic              sda_out,
  input wire logic              sda_oe_out,
  // Pins and interrupt
  input wire logic [PORT_W-1:0] port_pins_out,
  input wire logic [PORT_W-1:0] port_pins_oe_out,
  input wire logic              irq_n_out,
  input wire logic              irq_oe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  property p_rst_state;
    $fell(rst_in) |-> port_pins_out == '1 && port_pins_oe_out == '0 && !irq_oe_out && !sda_oe_out;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("outputs not at rest");
  property p_open_drain;
    sda_out == 1'b0 && irq_n_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain level high");
  property p_low_driven;
    (~port_pins_out & ~port_pins_oe_out) == '0;
  endproperty
  a_low_driven: assert property (p_low_driven) else $error("zero bit not driven");
  property p_ack_held;
    $rose(scl_in) && sda_oe_out |=> sda_oe_out [*4];
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("data line let go in high");
  property p_pullup_drop;
    $fell(scl_in) |-> ##[1:10] (port_pins_oe_out & port_pins_out) == '0;
  endproperty
  a_pullup_drop: assert property (p_pullup_drop) else $error("strong pull-up stays");
  property p_pullup_new;
    $rose(|(port_pins_oe_out & port_pins_out)) |-> $changed(port_pins_out);
  endproperty
  a_pullup_new: assert property (p_pullup_new) else $error("pull-up without write");
  // Latch moves only while the ack clock is high
  property p_latch_in_ack;
    $changed(port_pins_out) |-> $past(scl_in, 3);
  endproperty
  a_latch_in_ack: assert property (p_latch_in_ack) else $error("pins moved off ack");
  property p_start_quiet;
    scl_in && $past(scl_in) && $fell(sda_in) && !sda_oe_out |=> !sda_oe_out [*3];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("drive after start");

  c_ack: cover property ($rose(sda_oe_out));
  c_irq: cover property ($rose(irq_oe_out));
  c_pullup: cover property ($rose(|(port_pins_oe_out & port_pins_out)));
endmodule

bind qbx_top qbx_checker #(.PORT_W(PORT_W)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .port_pins_out(port_pins_out), .port_pins_oe_out(port_pins_oe_out),
  .irq_n_out(irq_n_out), .irq_oe_out(irq_oe_out)
);

`default_nettype wire

// ==== dv/qbx_top_test.sv ====
/*
  Self-checking bench for the expander top.
  Assumes the master model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none

module qbx_top_test;
  logic            clk_in = 1'b0;
  logic            rst_in = 1'b1;
  logic [2:0]      straps = 3'h0;
  logic [7:0]      ext_low = 8'h00;
  logic            ack_a;
  logic            ack_d;
  logic [7:0]      rdata;
  int              err_total = 0;
  int              checks = 0;
  wire logic       scl;
  wire logic       m_low;
  wire logic       sda_n;
  wire logic       sda_oe;
  wire logic       irq_n;
  wire logic       irq_oe;
  wire logic [7:0] pout;
  wire logic [7:0] poe;
  // Weak pull-up unless driven; bench pulls only undriven pins low
  wire logic [7:0] pins = (poe & pout) | (~poe & ~ext_low);
  wire logic       sda = !(m_low | sda_oe);
  // Written byte, then pins the bench pulls low
  logic [15:0]     rows [8] = '{16'hff00, 16'h0f05, 16'hf030, 16'ha5a0, 16'h5a42, 16'h0000, 16'h8180, 16'h7e3c};

  qbx_top #(.PORT_W(8), .HOLD_CYC(2)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_n), .sda_oe_out(sda_oe),
    .addr_select_straps_in(straps), .port_pins_in(pins), .port_pins_out(pout), .port_pins_oe_out(poe),
    .irq_n_out(irq_n), .irq_oe_out(irq_oe)
  );
  qbx_master_model mst (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));

  always #5 clk_in = ~clk_in;

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t ns: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    mst.start_cond();
    mst.put_byte(addr, ack_a);
    mst.put_byte(data, ack_d);
    mst.stop_cond();
    settle(10);
  endtask

  task automatic rd(input logic [7:0] addr);
    mst.start_cond();
    mst.put_byte(addr, ack_a);
    mst.get_byte(1'b1, rdata);
    mst.stop_cond();
    settle(10);
  endtask

  // Bounded by the 4 us limit
  task automatic wait_irq(input logic want);
    int n;
    n = 0;
    while (irq_oe !== want && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    check(irq_oe, {7'h0, want});
  endtask

  initial begin
    settle(6);
    rst_in <= 1'b0;
    settle(4);
    check(pout, 8'hff);
    check(poe, 8'h00);
    check({6'h00, irq_oe, sda_oe}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      straps <= i[2:0];
      ext_low <= 8'h00;
      settle(2);
      wr({4'h4, i[2:0], 1'b0}, rows[i][15:8]);
      check({ack_a, ack_d}, 8'h03);
      check(pout, rows[i][15:8]);
      check(poe, ~rows[i][15:8]);
      ext_low <= rows[i][7:0];
      settle(10);
      rd({4'h4, i[2:0], 1'b1});
      check(ack_a, 8'h01);
      check(rdata, rows[i][15:8] & ~rows[i][7:0]);
    end
    $display("test table done");
    ext_low <= 8'h00;
    wr(8'h4e, 8'hff);
    wr(8'h00, 8'h12);
    check(ack_a, 8'h00);
    wr(8'h4c, 8'h34);
    check(ack_a, 8'h00);
    check(pout, 8'hff);
    mst.start_cond();
    mst.put_byte(8'h4e, ack_a);
    mst.put_byte(8'ha5, ack_d);
    mst.put_byte(8'h0f, ack_a);
    mst.stop_cond();
    settle(10);
    check({ack_d, ack_a}, 8'h02);
    check(pout, 8'ha5);
    // Stop in mid-byte
    mst.start_cond();
    mst.put_byte(8'h4e, ack_a);
    for (int k = 0; k < 4; k++) mst.bit_io(1'b0, ack_d);
    mst.stop_cond();
    settle(10);
    check(pout, 8'ha5);
    $display("test refusals done");
    wr(8'h4e, 8'hff);
    ext_low <= 8'h10;
    wait_irq(1'b1);
    wr(8'h4c, 8'h00);
    check(irq_oe, 8'h01);
    ext_low <= 8'h00;
    wait_irq(1'b0);
    ext_low <= 8'h10;
    wait_irq(1'b1);
    rd(8'h4f);
    check(rdata, 8'hef);
    check(irq_oe, 8'h00);
    ext_low <= 8'h00;
    settle(10);
    mst.start_cond();
    mst.put_byte(8'h4e, ack_a);
    check(irq_oe, 8'h01);
    mst.put_byte(8'h00, ack_d);
    mst.stop_cond();
    settle(10);
    check(irq_oe, 8'h00);
    $display("test interrupt done");
    rst_in <= 1'b1;
    settle(6);
    rst_in <= 1'b0;
    settle(2);
    check(pout, 8'hff);
    check(poe, 8'h00);
    rd(8'h4f);
    check(rdata, 8'hff);
    $display("test second reset done");
    tally_and_finish();
  end

  // Whole run needs about 85 us
  initial begin
    #600000;
    err_total++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
